// ==== verilog/mem_regs.svh ====
// Constants for the two-port on-chip RAM and its APB register set.
// Assumes inclusion by the package and the top module only.
`ifndef MEM_REGS_SVH
`define MEM_REGS_SVH

// Memory shape
`define MEM_WIDTH 32
`define MEM_DEPTH 256
`define MEM_AW 8
`define MEM_GRAN 8
`define MEM_LANES 4
`define MEM_INIT_EN 1'b1
`define MEM_INIT_LEN 4

// APB register byte offsets
`define APB_AW 12
`define OFS_CFG0 12'h000
`define OFS_CFG1 12'h004
`define OFS_STAT0 12'h008
`define OFS_STAT1 12'h00C

// Port configuration field layout and reset value
`define CFG_W 7
`define CFG_RST 7'h01
`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 1
`define CFG_RSTINV_BIT 2
`define CFG_BYTEGRAN_BIT 3
`define CFG_GATE_BIT 4
`define CFG_ASYNC_BIT 5
`define CFG_WRCAP_BIT 6

// Status field layout
`define STAT_CNT_W 16
`define STAT_ADDR_LSB 16
`define STAT_ADDR_MSB 23
`define ZERO32 32'h0000_0000

`endif

// ==== verilog/mem_pkg.sv ====
// Types shared by the RAM top and its read-port module.
// Assumes mem_regs.svh is on the include path.
`default_nettype none
`include "mem_regs.svh"

package mem_pkg;

	typedef logic [`MEM_WIDTH-1:0] word_t;
	typedef logic [`MEM_AW-1:0] addr_t;
	typedef logic [`MEM_LANES-1:0] strobe_t;
	typedef word_t mem_array_t [0:`MEM_DEPTH-1];

	// Registered read behaviour during a write
	typedef enum logic [1:0] {
		MODE_READ_FIRST = 2'b00,
		MODE_WRITE_FIRST = 2'b01,
		MODE_HOLD = 2'b10
	} rd_mode_t;

	// Port configuration, bit order matches the CFG register
	typedef struct packed {
		logic write_capable;
		logic async_read;
		logic fetch_gate_opt;
		logic byte_gran;
		logic rst_invert;
		rd_mode_t mode;
	} port_cfg_t;

	// One user port request
	typedef struct packed {
		addr_t addr;
		strobe_t we;
		word_t wdata;
		logic rd_clock_en;
		logic rd_clear;
	} port_req_t;

	// Preload image, lowest addresses first
	localparam word_t INIT_LIST [0:`MEM_INIT_LEN-1] = '{
		32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008
	};

endpackage : mem_pkg
`default_nettype wire

// ==== verilog/mem_rd_port.sv ====
// Read-data path of one RAM port.
// Assumes the top supplies the stored word and the merged write word.
`default_nettype none

module mem_rd_port
(
	input wire logic pclk,
	input wire logic presetn,
	input wire mem_pkg::port_cfg_t cfg,
	input wire mem_pkg::word_t old_word,
	input wire mem_pkg::word_t new_word,
	input wire logic wr_act,
	input wire logic rd_clock_en,
	input wire logic rd_clear,
	output mem_pkg::word_t rd_data
);
	import mem_pkg::*;

	word_t data_reg;
	word_t data_next;
	logic fetch_ok;
	logic clr_hit;

	// Next read value per mode
	always_comb
	begin
		fetch_ok = ~cfg.fetch_gate_opt | rd_clock_en;
		clr_hit = cfg.rst_invert ? ~rd_clear : rd_clear;
		data_next = data_reg;
		if (clr_hit)
			data_next = word_t'(`ZERO32);
		else if (fetch_ok)
		begin
			case (cfg.mode)
				MODE_READ_FIRST: data_next = old_word;
				MODE_WRITE_FIRST:
					data_next = wr_act ? new_word : old_word;
				MODE_HOLD:
					data_next = wr_act ? data_reg : old_word;
				default: data_next = old_word;
			endcase
		end
	end

	// Read register on the port clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			data_reg <= word_t'(`ZERO32);
		else
			data_reg <= data_next;
	end

	// Combinational read bypasses the register
	assign rd_data = cfg.async_read ? old_word : data_reg;

endmodule : mem_rd_port
`default_nettype wire

// ==== verilog/mem_top.sv ====
// Two-port on-chip RAM with APB port configuration and status.
// Assumes both user ports and APB share pclk; inputs are synchronous.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`default_nettype none
`include "mem_regs.svh"

module mem_top
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire mem_pkg::port_req_t port0_req,
	output mem_pkg::word_t port0_rd_data,
	input wire mem_pkg::port_req_t port1_req,
	output mem_pkg::word_t port1_rd_data
);
	import mem_pkg::*;

	//------------------------------------------------------------
	// Preload image
	//------------------------------------------------------------

	// Build the configuration-time contents
	function automatic mem_array_t init_image();
		mem_array_t img;
		for (int i = 0; i < `MEM_DEPTH; i++)
		begin
			img[i] = word_t'(`ZERO32);
			if (`MEM_INIT_EN && i < `MEM_INIT_LEN)
				img[i] = INIT_LIST[i];
		end
		return img;
	endfunction : init_image

	// Merge enabled lanes of a write word into a stored word
	function automatic word_t merge_lanes(word_t old_w, word_t wr_w,
		strobe_t st);
		word_t res;
		res = old_w;
		for (int l = 0; l < `MEM_LANES; l++)
		begin
			if (st[l])
				res[l*`MEM_GRAN +: `MEM_GRAN] =
					wr_w[l*`MEM_GRAN +: `MEM_GRAN];
		end
		return res;
	endfunction : merge_lanes

	//------------------------------------------------------------
	// Storage
	//------------------------------------------------------------

	// Array has no reset; initial contents come from configuration only
	mem_array_t mem = init_image();

	port_cfg_t cfg0_reg;
	port_cfg_t cfg1_reg;
	logic [`STAT_CNT_W-1:0] wcnt0_reg;
	logic [`STAT_CNT_W-1:0] wcnt1_reg;
	addr_t last0_reg;
	addr_t last1_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic map_hit;

	strobe_t eff_we0;
	strobe_t eff_we1;
	word_t old0;
	word_t old1;
	word_t new0;
	word_t new1;
	logic wr_act0;
	logic wr_act1;

	//------------------------------------------------------------
	// Write strobes
	//------------------------------------------------------------

	// Effective strobes from capability and granularity
	always_comb
	begin
		eff_we0 = '0;
		eff_we1 = '0;
		if (cfg0_reg.write_capable)
			eff_we0 = cfg0_reg.byte_gran ? port0_req.we
				: {`MEM_LANES{port0_req.we[0]}};
		if (cfg1_reg.write_capable)
			eff_we1 = cfg1_reg.byte_gran ? port1_req.we
				: {`MEM_LANES{port1_req.we[0]}};
	end

	assign wr_act0 = |eff_we0;
	assign wr_act1 = |eff_we1;

	// Stored words at each port address
	assign old0 = mem[port0_req.addr];
	assign old1 = mem[port1_req.addr];

	// Words as they stand after each port's own write
	assign new0 = merge_lanes(old0, port0_req.wdata, eff_we0);
	assign new1 = merge_lanes(old1, port1_req.wdata, eff_we1);

	// Array writes; port 1 wins a same-lane collision
	always_ff @(posedge pclk)
	begin
		for (int l = 0; l < `MEM_LANES; l++)
		begin
			if (eff_we0[l])
				mem[port0_req.addr][l*`MEM_GRAN +: `MEM_GRAN] <=
					port0_req.wdata[l*`MEM_GRAN +: `MEM_GRAN];
			if (eff_we1[l])
				mem[port1_req.addr][l*`MEM_GRAN +: `MEM_GRAN] <=
					port1_req.wdata[l*`MEM_GRAN +: `MEM_GRAN];
		end
	end

	//------------------------------------------------------------
	// Read ports
	//------------------------------------------------------------

	// Two ports only, each with its own read path
	mem_rd_port u_rd0
	(
		.pclk(pclk),
		.presetn(presetn),
		.cfg(cfg0_reg),
		.old_word(old0),
		.new_word(new0),
		.wr_act(wr_act0),
		.rd_clock_en(port0_req.rd_clock_en),
		.rd_clear(port0_req.rd_clear),
		.rd_data(port0_rd_data)
	);

	mem_rd_port u_rd1
	(
		.pclk(pclk),
		.presetn(presetn),
		.cfg(cfg1_reg),
		.old_word(old1),
		.new_word(new1),
		.wr_act(wr_act1),
		.rd_clock_en(port1_req.rd_clock_en),
		.rd_clear(port1_req.rd_clear),
		.rd_data(port1_rd_data)
	);

	//------------------------------------------------------------
	// Port status
	//------------------------------------------------------------

	// Write counters and last written address, port 0
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wcnt0_reg <= '0;
			last0_reg <= '0;
		end
		else if (wr_act0)
		begin
			wcnt0_reg <= wcnt0_reg + 1'b1;
			last0_reg <= port0_req.addr;
		end
	end

	// Write counters and last written address, port 1
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wcnt1_reg <= '0;
			last1_reg <= '0;
		end
		else if (wr_act1)
		begin
			wcnt1_reg <= wcnt1_reg + 1'b1;
			last1_reg <= port1_req.addr;
		end
	end

	//------------------------------------------------------------
	// APB slave
	//------------------------------------------------------------

	// Address decode and read mux
	always_comb
	begin
		map_hit = 1'b1;
		prdata_next = `ZERO32;
		case (paddr)
			`OFS_CFG0: prdata_next[`CFG_W-1:0] = cfg0_reg;
			`OFS_CFG1: prdata_next[`CFG_W-1:0] = cfg1_reg;
			`OFS_STAT0:
			begin
				prdata_next[`STAT_CNT_W-1:0] = wcnt0_reg;
				prdata_next[`STAT_ADDR_MSB:`STAT_ADDR_LSB] = last0_reg;
			end
			`OFS_STAT1:
			begin
				prdata_next[`STAT_CNT_W-1:0] = wcnt1_reg;
				prdata_next[`STAT_ADDR_MSB:`STAT_ADDR_LSB] = last1_reg;
			end
			default: map_hit = 1'b0;
		endcase
	end

	// One wait state: ready on the second access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= `ZERO32;
		end
		else
		begin
			pready_reg <= psel & penable & ~pready_reg;
			pslverr_reg <= psel & penable & ~pready_reg & ~map_hit;
			if (psel & penable & ~pready_reg & ~pwrite)
				prdata_reg <= prdata_next;
		end
	end

	// Configuration writes take effect with the ready edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg0_reg <= port_cfg_t'(`CFG_RST);
			cfg1_reg <= port_cfg_t'(`CFG_RST);
		end
		else if (psel & penable & pready_reg & pwrite)
		begin
			if (paddr == `OFS_CFG0)
				cfg0_reg <= port_cfg_t'(pwdata[`CFG_W-1:0]);
			if (paddr == `OFS_CFG1)
				cfg1_reg <= port_cfg_t'(pwdata[`CFG_W-1:0]);
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;

endmodule : mem_top
`default_nettype wire

// ==== bench/mem_chk_assertions.sv ====
// Assertions on APB timing and the port 0 read path of mem_top.
// Assumes a bind to mem_top; mirrors CFG0 from APB writes.
`default_nettype none
module mem_chk
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire mem_pkg::port_req_t port0_req,
	input wire mem_pkg::word_t port0_rd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	import mem_pkg::*;
	port_cfg_t c;
	logic wr, go, wf, clr;
	word_t m;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Mirror of the port 0 config
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			c <= 7'h01;
		else if (psel && penable && pready && pwrite && paddr == 12'h000)
			c <= pwdata[6:0];
	end
	// Lane mask, effective write, open read register
	assign m = {{8{port0_req.we[3]}}, {8{port0_req.we[2]}},
		{8{port0_req.we[1]}}, {8{port0_req.we[0]}}};
	assign wr = c.write_capable
		&& (c.byte_gran ? |port0_req.we : port0_req.we[0]);
	assign clr = port0_req.rd_clear ^ c.rst_invert;
	assign go = !c.async_read && !clr;
	assign wf = c.mode == MODE_WRITE_FIRST && wr && go
		&& (!c.fetch_gate_opt || port0_req.rd_clock_en);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	property p_wait;
		s_setup ##1 s_access |=> pready;
	endproperty
	property p_pulse;
		pready |=> !pready;
	endproperty
	property p_bad;
		psel && penable && pready && paddr > 12'h00C |-> pslverr;
	endproperty
	property p_wfirst;
		wf && !c.byte_gran |=> port0_rd_data == $past(port0_req.wdata);
	endproperty
	property p_lane;
		wf && c.byte_gran |=>
			(port0_rd_data & $past(m)) == ($past(port0_req.wdata) & $past(m));
	endproperty
	property p_hold;
		c.mode == MODE_HOLD && wr && go |=> $stable(port0_rd_data);
	endproperty
	property p_gate;
		c.fetch_gate_opt && !port0_req.rd_clock_en && go
			|=> $stable(port0_rd_data);
	endproperty
	property p_clear;
		!c.async_read && clr |=> port0_rd_data == 32'h0000_0000;
	endproperty
	a_wait: assert property (p_wait) else $error("late ready");
	a_pulse: assert property (p_pulse) else $error("long ready");
	a_bad: assert property (p_bad) else $error("no error");
	a_wfirst: assert property (p_wfirst) else $error("wfirst");
	a_lane: assert property (p_lane) else $error("lane");
	a_hold: assert property (p_hold) else $error("hold");
	a_gate: assert property (p_gate) else $error("gate");
	a_clear: assert property (p_clear) else $error("clear");
endmodule : mem_chk
bind mem_top mem_chk u_mem_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .port0_req, .port0_rd_data);
`default_nettype wire

// ==== bench/user_port.sv ====
// Model of the user logic on RAM port 1.
// Assumes the bench hands it one request per pclk edge.
`default_nettype none
module user_port
(
	input wire logic pclk,
	input wire logic presetn,
	input wire mem_pkg::port_req_t cmd,
	output mem_pkg::port_req_t req
);
	timeunit 1ns;
	timeprecision 1ns;
	import mem_pkg::*;
	// Registers requests; idle data lines toggle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			req <= '0;
		else
		begin
			if (cmd.we == 4'h0)
				req <= {cmd.addr, cmd.we, ~req.wdata, cmd.rd_clock_en,
					cmd.rd_clear};
			else
				req <= cmd;
		end
	end
endmodule : user_port
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the two-port RAM.
// Assumes mem_top, user_port and the checker are compiled first.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mem_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, e;
	logic [11:0] paddr = 12'h000;
	word_t pwdata = 32'h0000_0000, prdata, q, r0, r1, d;
	port_req_t p0 = '0, c1 = '0, p1;
	word_t sh [0:255];
	addr_t a;
	strobe_t w;
	int miscompares = 0, total_checks = 0;
	mem_top u_mem_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .port0_req(p0),
		.port0_rd_data(r0), .port1_req(p1), .port1_rd_data(r1));
	user_port u_user_port (.pclk, .presetn, .cmd(c1), .req(p1));
	always #5 pclk = ~pclk;
	task chk(input word_t g, input word_t x);
		total_checks++;
		if (g !== x)
		begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	// APB transfer; waits for ready
	task apb(input logic wn, input logic [11:0] ad, input word_t wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wn;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One port 0 request, result settled after the edge
	task pr(input addr_t ad, input strobe_t s, input word_t wd,
		input logic ce, input logic cl);
		@(posedge pclk);
		p0 <= {ad, s, wd, ce, cl};
		@(posedge pclk);
		#1;
	endtask : pr
	function automatic word_t merge(word_t o, word_t n, strobe_t s);
		for (int l = 0; l < 4; l++)
			if (s[l])
				o[8*l+:8] = n[8*l+:8];
		return o;
	endfunction : merge
	function automatic word_t exp_rd(int md, word_t o, word_t n, word_t pv);
		return md == 0 ? o : (md == 2 ? pv : n);
	endfunction : exp_rd
	initial
	begin
		#50000;
		miscompares++;
		close_out;
	end
	initial
	begin
		void'($urandom(32'h2fdd_491c));
		for (int i = 0; i < 256; i++)
			sh[i] = i < 4 ? 32'h0000_0001 << i : 32'h0000_0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk(r0, 32'h0000_0000);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		for (int i = 0; i < 4; i++)
		begin
			pr(i[7:0], 4'h0, 32'h0000_0000, 1'b1, 1'b0);
			chk(r0, sh[i]);
		end
		pr(8'h05, 4'hF, 32'h1234_5678, 1'b1, 1'b0);
		pr(8'h05, 4'h0, 32'h0000_0000, 1'b1, 1'b0);
		chk(r0, sh[5]);
		$display("test init done");
		for (int md = 0; md < 3; md++)
		begin
			a = 8'($urandom_range(255, 4));
			d = $urandom;
			apb(1'b1, 12'h000, {25'h000_0000, 5'h10, md[1:0]});
			pr(md[7:0], 4'h0, 32'h0000_0000, 1'b1, 1'b0);
			pr(a, 4'hF, d, 1'b1, 1'b0);
			chk(r0, exp_rd(md, sh[a], d, sh[md]));
			sh[a] = d;
			pr(a, 4'h0, 32'h0000_0000, 1'b1, 1'b0);
			chk(r0, d);
		end
		$display("test modes done");
		for (int k = 0; k < 6; k++)
		begin
			a = 8'($urandom_range(255, 4));
			d = $urandom;
			w = k > 0 ? 4'($urandom) : 4'h1;
			apb(1'b1, 12'h000, k > 0 ? 32'h0000_0049 : 32'h0000_0041);
			pr(a, w, d, 1'b1, 1'b0);
			sh[a] = merge(sh[a], d, k > 0 ? w : {4{w[0]}});
			chk(r0, sh[a]);
		end
		$display("test lanes done");
		apb(1'b1, 12'h000, 32'h0000_0051);
		pr(8'h00, 4'h0, 32'h0000_0000, 1'b1, 1'b0);
		pr(8'h01, 4'hF, d, 1'b0, 1'b0);
		chk(r0, sh[0]);
		sh[1] = d;
		pr(8'h01, 4'h0, 32'h0000_0000, 1'b1, 1'b0);
		chk(r0, d);
		apb(1'b1, 12'h000, 32'h0000_0031);
		@(posedge pclk);
		p0 <= {8'h02, 4'h0, 32'h0000_0000, 1'b0, 1'b0};
		#1;
		chk(r0, sh[2]);
		$display("test gate done");
		apb(1'b1, 12'h000, 32'h0000_0041);
		pr(8'h01, 4'h0, 32'h0000_0000, 1'b1, 1'b1);
		chk(r0, 32'h0000_0000);
		apb(1'b1, 12'h000, 32'h0000_0045);
		pr(8'h01, 4'h0, 32'h0000_0000, 1'b1, 1'b1);
		chk(r0, d);
		pr(8'h01, 4'h0, 32'h0000_0000, 1'b1, 1'b0);
		chk(r0, 32'h0000_0000);
		apb(1'b1, 12'h004, 32'h0000_0041);
		a = 8'($urandom_range(255, 4));
		d = $urandom;
		@(posedge pclk);
		c1 <= {a, 4'hF, d, 1'b1, 1'b0};
		repeat (2) @(posedge pclk);
		#1;
		chk(r1, d);
		pr(a, 4'h0, 32'h0000_0000, 1'b1, 1'b1);
		chk(r0, d);
		$display("test clear and port1 done");
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk({24'h00_0000, q[23:16]}, {24'h00_0000, a});
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk(r0, 32'h0000_0000);
		pr(a, 4'h0, 32'h0000_0000, 1'b1, 1'b0);
		chk(r0, d);
		$display("test reset done");
		close_out;
	end
endmodule : testbench
`default_nettype wire
